/* File: cfs_pkg.sv */
// Operation
// - identifier is two bytes; upper byte 3f root, 7f first-level, 5f second-level directory.
// - data file upper byte names its parent: 2f root, 6f first-level, 4f second-level.
// - no identifier repeats among siblings or between a file and any ancestor.
// - after reset the root file is selected and is the current directory.
// - selecting a directory or root sets current directory and clears current data file.
// - selecting a data file makes it current; its parent becomes current directory.
// - selectable: children, sibling directories, parent, current directory itself, and root.
// - reselecting the most recently selected file is always accepted.
// - application command runs only when owned by the current directory.
// - byte-sequence access uses offset plus count; offset 0000 is the first body byte.
// - fixed-record files hold equal records numbered from 1; header keeps length and size.
// - pointer unset allows first/last; set allows current, next unless last, previous unless first.
// - search starts from file start, after pointer, file end, or before pointer.
// - an aborted record action restores the pointer it held before the action.
// - record files hold at most 255 records of at most 255 bytes.
// - key files are reached only by absolute record number.
// - a full cyclic file stores the next entry over the oldest record.
// - cyclic stepping wraps from record n to 1 and from 1 to n.
// - cyclic record 1 holds the newest data, record n the oldest.
// - cyclic updates use previous addressing only; reads use next, previous, current, number.
// - selecting a cyclic file points at the record updated last.
// - header attributes of the selected file are returned by response and status; status gives the current directory fid and kind, data file sizes.
package cfs_pkg;

    localparam int          CFS_IDX_W    = 4;
    localparam logic [15:0] ROOT_FID     = 16'h3f00;
    localparam logic [7:0]  TAG_ROOT     = 8'h3f;
    localparam logic [7:0]  TAG_DIR1     = 8'h7f;
    localparam logic [7:0]  TAG_DIR2     = 8'h5f;
    localparam logic [7:0]  TAG_DATA_RT  = 8'h2f;
    localparam logic [7:0]  TAG_DATA_D1  = 8'h6f;
    localparam logic [7:0]  TAG_DATA_D2  = 8'h4f;
    localparam logic [7:0]  FIRST_REC    = 8'h01;
    localparam logic [15:0] FIRST_OFFSET = 16'h0000;

    typedef enum logic [1:0] {K_ROOT, K_DIR1, K_DIR2, K_DATA} cfs_kind_e;
    typedef enum logic [1:0] {S_BYTES, S_LINEAR, S_KEYED, S_CYCLIC} cfs_struc_e;
    typedef enum logic [2:0] {
        OP_SELECT, OP_STATUS, OP_CREATE, OP_RECORD, OP_BYTES, OP_COMMIT, OP_ABORT, OP_APP_CHECK
    } cfs_op_e;
    typedef enum logic [3:0] {
        M_ABS, M_FIRST, M_LAST, M_NEXT, M_PREV, M_CUR, M_SK_START, M_SK_AFTER, M_SK_END, M_SK_BEFORE
    } cfs_mode_e;

    typedef struct packed {
        logic                 valid;
        logic [15:0]          fid;
        logic [CFS_IDX_W-1:0] parent;
        cfs_kind_e            kind;
        cfs_struc_e           struc;
        logic [7:0]           rec_len;
        logic [7:0]           rec_cnt;
        logic [15:0]          body_len;
        logic [7:0]           base;
    } cfs_entry_s;

    typedef struct packed {
        logic        valid;
        cfs_op_e     op;
        cfs_mode_e   mode;
        logic        update;
        logic [15:0] fid;
        logic [7:0]  rec_num;
        logic [15:0] offset;
        logic [7:0]  count;
        cfs_struc_e  struc;
        logic [7:0]  rec_len;
        logic [7:0]  rec_cnt;
        logic [15:0] body_len;
    } cfs_req_s;

    typedef struct packed {
        logic        done;
        logic        ok;
        logic [15:0] fid;
        cfs_kind_e   kind;
        cfs_struc_e  struc;
        logic [7:0]  rec_len;
        logic [15:0] file_size;
        logic [15:0] body_len;
        logic [7:0]  rec_log;
        logic [7:0]  rec_phys;
        logic        seek;
        logic        seek_bwd;
    } cfs_rsp_s;

endpackage : cfs_pkg

/* File: cfs_card_file_selector.sv */
`timescale 1ns/100ps
module cfs_card_file_selector #(
    parameter int N_FILES = 16
) (
    clk,
    srst,
    req,
    rsp,
    cur_dir_fid,
    cur_ef_fid,
    ef_selected
);
    import cfs_pkg::*;

    input  wire logic             clk;
    input  wire logic             srst;
    input  wire cfs_pkg::cfs_req_s req;
    output cfs_pkg::cfs_rsp_s     rsp;
    output logic [15:0]           cur_dir_fid;
    output logic [15:0]           cur_ef_fid;
    output logic                  ef_selected;

    typedef logic [CFS_IDX_W-1:0] cfs_idx_t;

    typedef struct packed {
        cfs_entry_s [N_FILES-1:0] tbl;
        cfs_idx_t                 used;
        cfs_idx_t                 cur_dir;
        cfs_idx_t                 cur_ef;
        logic                     ef_valid;
        cfs_idx_t                 last_sel;
        logic [7:0]               ptr;
        logic                     ptr_set;
        logic [7:0]               sav_ptr;
        logic                     sav_set;
        logic                     pend_rot;
        cfs_rsp_s                 rsp;
    } cfs_state_s;

    cfs_state_s st_q;
    cfs_state_s st_d;

    ////////////////////////////////////////////////////////////////////////////
    // parallel identifier match over the whole file table

    cfs_entry_s       cd_e;
    cfs_entry_s       ef_e;
    cfs_idx_t         anc1;
    cfs_idx_t         anc2;
    logic [N_FILES-1:0] sel_hit;
    logic [N_FILES-1:0] dup_hit;

    assign cd_e = st_q.tbl[st_q.cur_dir];
    assign ef_e = st_q.tbl[st_q.cur_ef];
    assign anc1 = cd_e.parent;
    assign anc2 = st_q.tbl[anc1].parent;

    for (genvar i = 0; i < N_FILES; i++) begin : g_match
        localparam cfs_idx_t I = CFS_IDX_W'(i);
        cfs_entry_s e;
        logic       same;
        assign e    = st_q.tbl[i];
        assign same = e.valid && (e.fid == req.fid);
        assign sel_hit[i] = same && ((e.parent == st_q.cur_dir)
                          || (e.kind != K_DATA && st_q.cur_dir != '0 && e.parent == anc1 && I != '0)
                          || I == anc1 || I == st_q.cur_dir || I == '0
                          || I == st_q.last_sel);
        assign dup_hit[i] = same && ((e.parent == st_q.cur_dir && I != '0)
                          || I == st_q.cur_dir || I == anc1 || I == anc2);
    end

    function automatic cfs_idx_t first_hit(input logic [N_FILES-1:0] v);
        cfs_idx_t r;
        r = '0;
        for (int k = N_FILES - 1; k >= 0; k--) begin
            if (v[k]) begin
                r = CFS_IDX_W'(k);
            end
        end
        return r;
    endfunction : first_hit

    // logical record to stored slot, rotated so record 1 is always newest
    function automatic logic [7:0] to_phys(input logic [7:0] base, input logic [7:0] lg, input logic [7:0] n);
        logic [8:0] s;
        s = {1'b0, base} + {1'b0, lg} - 9'h001;
        if (s >= {1'b0, n}) begin
            s = s - {1'b0, n};
        end
        return 8'(s + 9'h001);
    endfunction : to_phys

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        cfs_idx_t   t;
        cfs_entry_s te;
        cfs_entry_s ne;
        logic [7:0] n;
        logic [7:0] tgt;
        logic       rok;
        logic       cyc;
        logic       kok;
        logic [7:0] tag;
        logic [16:0] span;
        t    = first_hit(sel_hit);
        te   = st_q.tbl[t];
        ne   = '0;
        n    = ef_e.rec_cnt;
        tgt  = '0;
        rok  = 1'b0;
        cyc  = (ef_e.struc == S_CYCLIC);
        kok  = 1'b0;
        tag  = req.fid[15:8];
        span = {1'b0, req.offset} + {9'h000, req.count};
        st_d = st_q;
        st_d.rsp = '0;

        if (req.valid) begin
            st_d.rsp.done = 1'b1;
            unique case (req.op)
                OP_SELECT: begin
                    if (|sel_hit) begin
                        st_d.rsp.ok   = 1'b1;
                        st_d.last_sel = t;
                        st_d.ptr      = FIRST_REC;
                        st_d.ptr_set  = (te.kind == K_DATA) && (te.struc == S_CYCLIC);
                        st_d.pend_rot = 1'b0;
                        if (te.kind == K_DATA) begin
                            st_d.cur_ef   = t;
                            st_d.cur_dir  = te.parent;
                            st_d.ef_valid = 1'b1;
                        end else begin
                            st_d.cur_dir  = t;
                            st_d.ef_valid = 1'b0;
                        end
                        st_d.rsp.fid       = te.fid;
                        st_d.rsp.kind      = te.kind;
                        st_d.rsp.struc     = te.struc;
                        st_d.rsp.rec_len   = te.rec_len;
                        st_d.rsp.file_size = 16'(te.rec_len) * 16'(te.rec_cnt);
                        st_d.rsp.body_len  = te.body_len;
                    end
                    // otherwise nothing moves
                end
                OP_STATUS: begin
                    st_d.rsp.ok        = 1'b1;
                    st_d.rsp.fid       = cd_e.fid;
                    st_d.rsp.kind      = cd_e.kind;
                    st_d.rsp.struc     = ef_e.struc;
                    st_d.rsp.rec_len   = st_q.ef_valid ? ef_e.rec_len : '0;
                    st_d.rsp.file_size = st_q.ef_valid ? 16'(ef_e.rec_len) * 16'(ef_e.rec_cnt) : '0;
                    st_d.rsp.body_len  = st_q.ef_valid ? ef_e.body_len : '0;
                    st_d.rsp.rec_log   = st_q.ptr;
                end
                OP_CREATE: begin
                    unique case (cd_e.kind)
                        K_ROOT:  kok = (tag == TAG_DIR1) || (tag == TAG_DATA_RT);
                        K_DIR1:  kok = (tag == TAG_DIR2) || (tag == TAG_DATA_D1);
                        K_DIR2:  kok = (tag == TAG_DATA_D2);
                        K_DATA:  kok = 1'b0;
                    endcase
                    ne.valid    = 1'b1;
                    ne.fid      = req.fid;
                    ne.parent   = st_q.cur_dir;
                    ne.kind     = (tag == TAG_DIR1) ? K_DIR1 : (tag == TAG_DIR2) ? K_DIR2 : K_DATA;
                    ne.struc    = req.struc;
                    ne.rec_len  = req.rec_len;
                    ne.rec_cnt  = req.rec_cnt;
                    ne.body_len = (req.struc == S_BYTES) ? req.body_len : 16'(req.rec_len) * 16'(req.rec_cnt);
                    if (ne.kind == K_DATA && req.struc != S_BYTES && (req.rec_len == '0 || req.rec_cnt == '0)) begin
                        kok = 1'b0;
                    end
                    if (kok && !(|dup_hit) && st_q.used != cfs_idx_t'(N_FILES - 1)
                        && tag != TAG_ROOT) begin
                        st_d.rsp.ok = 1'b1;
                        st_d.tbl[st_q.used + cfs_idx_t'(1)] = ne;
                        st_d.used   = st_q.used + cfs_idx_t'(1);
                        st_d.rsp.fid = req.fid;
                    end
                end
                OP_RECORD: begin
                    unique case (req.mode)
                        M_ABS: begin
                            rok = req.rec_num >= FIRST_REC && req.rec_num <= n;
                            tgt = req.rec_num;
                        end
                        M_FIRST, M_SK_START: begin
                            rok = !st_q.ptr_set || req.mode == M_SK_START;
                            tgt = FIRST_REC;
                        end
                        M_LAST, M_SK_END: begin
                            rok = !st_q.ptr_set || req.mode == M_SK_END;
                            tgt = n;
                        end
                        M_NEXT, M_SK_AFTER: begin
                            rok = st_q.ptr_set && (st_q.ptr < n || (cyc && req.mode == M_NEXT));
                            tgt = (st_q.ptr < n) ? 8'(st_q.ptr + FIRST_REC) : FIRST_REC;
                        end
                        M_PREV, M_SK_BEFORE: begin
                            rok = st_q.ptr_set && (st_q.ptr > FIRST_REC || (cyc && req.mode == M_PREV));
                            tgt = (st_q.ptr > FIRST_REC) ? 8'(st_q.ptr - FIRST_REC) : n;
                        end
                        M_CUR: begin
                            rok = st_q.ptr_set;
                            tgt = st_q.ptr;
                        end
                        default: begin
                            rok = 1'b0;
                            tgt = '0;
                        end
                    endcase
                    if (ef_e.struc == S_KEYED && req.mode != M_ABS) begin
                        rok = 1'b0;
                    end
                    if (cyc && req.update) begin
                        rok = (req.mode == M_PREV);
                        tgt = n;
                    end
                    if (!st_q.ef_valid || ef_e.struc == S_BYTES) begin
                        rok = 1'b0;
                    end
                    if (rok) begin
                        st_d.rsp.ok       = 1'b1;
                        st_d.sav_ptr      = st_q.ptr;
                        st_d.sav_set      = st_q.ptr_set;
                        st_d.ptr          = tgt;
                        st_d.ptr_set      = 1'b1;
                        st_d.pend_rot     = cyc && req.update;
                        st_d.rsp.rec_log  = tgt;
                        st_d.rsp.rec_phys = cyc ? to_phys(ef_e.base, tgt, n) : tgt;
                        st_d.rsp.rec_len  = ef_e.rec_len;
                        st_d.rsp.seek     = req.mode >= M_SK_START;
                        st_d.rsp.seek_bwd = req.mode == M_SK_END || req.mode == M_SK_BEFORE;
                    end
                end
                OP_BYTES: begin
                    if (st_q.ef_valid && ef_e.struc == S_BYTES && span <= {1'b0, ef_e.body_len}) begin
                        st_d.rsp.ok       = 1'b1;
                        st_d.rsp.body_len = ef_e.body_len;
                        st_d.rsp.file_size = req.offset - FIRST_OFFSET;
                    end
                end
                OP_COMMIT: begin
                    st_d.rsp.ok   = 1'b1;
                    st_d.pend_rot = 1'b0;
                    if (st_q.pend_rot) begin
                        // slot of old record n becomes record 1, newest first
                        st_d.tbl[st_q.cur_ef].base = (ef_e.base == '0) ? 8'(n - FIRST_REC)
                                                                         : 8'(ef_e.base - FIRST_REC);
                        st_d.ptr = FIRST_REC;
                    end else if (req.rec_num != '0 && req.rec_num <= n) begin
                        st_d.ptr = req.rec_num;
                    end
                    st_d.sav_ptr = st_d.ptr;
                    st_d.sav_set = st_q.ptr_set;
                end
                OP_ABORT: begin
                    st_d.rsp.ok   = 1'b1;
                    st_d.ptr      = st_q.sav_ptr;
                    st_d.ptr_set  = st_q.sav_set;
                    st_d.pend_rot = 1'b0;
                end
                OP_APP_CHECK: begin
                    st_d.rsp.ok  = (req.fid == cd_e.fid);
                    st_d.rsp.fid = cd_e.fid;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; root entry preloaded so it is selected from reset

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q              <= '0;
            st_q.tbl[0].valid <= 1'b1;
            st_q.tbl[0].fid   <= ROOT_FID;
            st_q.tbl[0].kind  <= K_ROOT;
        end else begin
            st_q <= st_d;
        end
    end

    assign rsp         = st_q.rsp;
    assign cur_dir_fid = cd_e.fid;
    assign cur_ef_fid  = st_q.ef_valid ? ef_e.fid : '0;
    assign ef_selected = st_q.ef_valid;

endmodule : cfs_card_file_selector

/* File: cfs_card_file_selector_checker.sv */
`timescale 1ns/100ps
module cfs_card_file_selector_checker #(
    parameter int N_FILES = 16
) (
    input wire logic              clk,
    input wire logic              srst,
    input wire cfs_pkg::cfs_req_s req,
    input wire cfs_pkg::cfs_rsp_s rsp,
    input wire logic [15:0]       cur_dir_fid,
    input wire logic [15:0]       cur_ef_fid,
    input wire logic              ef_selected
);
    import cfs_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////
    chk_answer_next: assert property (
        req.valid |=> rsp.done)
        else $error("request not answered in the next cycle");
    // reset attempt must not be disabled by its own antecedent
    chk_reset_root: assert property (disable iff (1'b0)
        srst |=> cur_dir_fid == ROOT_FID && !ef_selected)
        else $error("root not current after reset");
    chk_dir_select: assert property (
        rsp.done && rsp.ok && $past(req.op) == OP_SELECT && rsp.kind != K_DATA
        |-> cur_dir_fid == rsp.fid && !ef_selected)
        else $error("directory selection did not set directory");
    chk_ef_select: assert property (
        rsp.done && rsp.ok && $past(req.op) == OP_SELECT && rsp.kind == K_DATA
        |-> ef_selected && cur_ef_fid == rsp.fid && cur_ef_fid[15:8] ==
            (cur_dir_fid[15:8] == TAG_ROOT ? TAG_DATA_RT :
             cur_dir_fid[15:8] == TAG_DIR1 ? TAG_DATA_D1 : TAG_DATA_D2))
        else $error("data file not a child of current directory");
    chk_refuse_hold: assert property (
        rsp.done && !rsp.ok
        |-> $stable(cur_dir_fid) && $stable(cur_ef_fid) && $stable(ef_selected))
        else $error("refused request changed selection");
    chk_kind_tag: assert property (
        rsp.done && rsp.ok && $past(req.op) == OP_SELECT
        |-> rsp.fid == $past(req.fid)
            && (rsp.kind == K_ROOT) == (rsp.fid[15:8] == TAG_ROOT)
            && (rsp.kind == K_DIR1) == (rsp.fid[15:8] == TAG_DIR1)
            && (rsp.kind == K_DIR2) == (rsp.fid[15:8] == TAG_DIR2))
        else $error("file kind does not match identifier byte");
    chk_app_owner: assert property (
        rsp.done && $past(req.op) == OP_APP_CHECK
        |-> rsp.ok == ($past(req.fid) == $past(cur_dir_fid)))
        else $error("application check against wrong directory");
    chk_first_rec: assert property (
        rsp.done && rsp.ok && $past(req.op) == OP_RECORD && $past(req.mode) == M_FIRST
        |-> rsp.rec_log == FIRST_REC)
        else $error("first record access not on record one");
endmodule : cfs_card_file_selector_checker

bind cfs_card_file_selector cfs_card_file_selector_checker #(.N_FILES(N_FILES)) chk_inst (
    .clk(clk), .srst(srst), .req(req), .rsp(rsp),
    .cur_dir_fid(cur_dir_fid), .cur_ef_fid(cur_ef_fid), .ef_selected(ef_selected));

/* File: cfs_host_model.sv */
`timescale 1ns/100ps
module cfs_host_model (
    input wire logic          clk,
    output cfs_pkg::cfs_req_s req
);
    import cfs_pkg::*;
    initial req = '0;
    // caller is at a falling edge; held over exactly one rising edge
    task automatic send(input cfs_req_s r);
        req = r;
        @(negedge clk);
    endtask : send
    // released fields show the inverse so a stale value never passes
    task automatic idle();
        cfs_req_s t;
        t = ~req;
        t.valid = 1'b0;
        req = t;
    endtask : idle
endmodule : cfs_host_model

/* File: cfs_card_file_selector_tb_top.sv */
`timescale 1ns/100ps
module cfs_card_file_selector_tb_top;
    import cfs_pkg::*;
    typedef struct packed {
        logic        ok;
        logic [15:0] dir;
        logic        ef;
        logic [15:0] eid;
        logic [1:0]  sel;
        logic [15:0] val;
    } cfs_exp_s;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    cfs_req_s    req;
    cfs_rsp_s    rsp;
    logic [15:0] cur_dir_fid;
    logic [15:0] cur_ef_fid;
    logic        ef_selected;
    cfs_exp_s    q[$];
    cfs_exp_s    e;
    cfs_req_s    r;
    logic [15:0] ed = ROOT_FID;
    logic        ee = 1'b0;
    logic [15:0] ei = 16'h0000;
    int          n_fail = 0;
    int          checked = 0;
    int          o;
    int          c;
    always #25 clk = ~clk;
    cfs_host_model cfs_host_model_inst (.clk(clk), .req(req));
    cfs_card_file_selector #(.N_FILES(8)) cfs_card_file_selector_inst (
        .clk(clk), .srst(srst), .req(req), .rsp(rsp),
        .cur_dir_fid(cur_dir_fid), .cur_ef_fid(cur_ef_fid), .ef_selected(ef_selected));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("checked %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    task automatic go(input logic ok, input logic [1:0] sel, input logic [15:0] val);
        q.push_back(cfs_exp_s'{ok, ed, ee, ei, sel, val});
        r.valid = 1'b1;
        cfs_host_model_inst.send(r);
    endtask : go
    task automatic sel_(input logic [15:0] fid, input logic ok);
        r = '0;
        r.op = OP_SELECT;
        r.fid = fid;
        if (ok && fid[15:8] inside {TAG_DATA_RT, TAG_DATA_D1, TAG_DATA_D2}) begin
            ee = 1'b1;
            ei = fid;
        end else if (ok) begin
            ed = fid;
            ee = 1'b0;
            ei = 16'h0000;
        end
        go(ok, 2'd0, 16'h0000);
    endtask : sel_
    task automatic cr_(input logic [15:0] fid, input cfs_struc_e s, input logic ok);
        r = '0;
        r.op = OP_CREATE;
        r.fid = fid;
        r.struc = s;
        r.rec_len = 8'h04;
        r.rec_cnt = 8'h03;
        r.body_len = 16'h0010;
        go(ok, 2'd0, 16'h0000);
    endtask : cr_
    // fid doubles as byte offset and n as byte count for byte access
    task automatic op_(input cfs_op_e op, input cfs_mode_e m, input logic u, input logic [15:0] fid,
                       input logic [7:0] n, input logic ok, input logic [1:0] sel, input logic [15:0] v);
        r = '0;
        r.op = op;
        r.mode = m;
        r.update = u;
        r.fid = fid;
        r.offset = fid;
        r.rec_num = n;
        r.count = n;
        go(ok, sel, v);
    endtask : op_
    task automatic rec_(input cfs_mode_e m, input logic [7:0] n, input logic ok, input logic [7:0] v);
        logic sk;
        logic bk;
        sk = m inside {M_SK_START, M_SK_AFTER, M_SK_END, M_SK_BEFORE};
        bk = m inside {M_SK_END, M_SK_BEFORE};
        op_(OP_RECORD, m, 1'b0, 16'h0000, n, ok, {1'b0, v != 8'h00}, {6'h00, sk, bk, v});
    endtask : rec_
    always @(posedge clk) begin
        #1;
        if (rsp.done === 1'b1 && q.size() == 0) chk(16'h0001, 16'h0000);
        else if (rsp.done === 1'b1) begin
            e = q.pop_front();
            chk(16'(rsp.ok), 16'(e.ok));
            chk(cur_dir_fid, e.dir);
            chk(16'(ef_selected), 16'(e.ef));
            chk(cur_ef_fid, e.eid);
            if (e.sel == 2'd1) chk(16'(rsp.rec_log), {8'h00, e.val[7:0]});
            if (e.sel == 2'd1) chk(16'({rsp.seek, rsp.seek_bwd}), 16'(e.val[9:8]));
            if (e.sel == 2'd2) chk(rsp.file_size, e.val);
            if (e.sel == 2'd3) chk(16'(rsp.rec_phys), e.val);
        end
    end
    initial begin
        #(50 * 3000);
        n_fail++;
        test_done();
    end
    initial begin
        o = $urandom(13);
        repeat (3) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        sel_(ROOT_FID, 1'b1);
        cr_(16'h7f10, S_BYTES, 1'b1);
        cr_(16'h7f20, S_BYTES, 1'b1);
        cr_(16'h2f05, S_BYTES, 1'b1);
        cr_(16'h7f10, S_BYTES, 1'b0);
        cr_(16'h6f09, S_BYTES, 1'b0);
        sel_(16'h7f10, 1'b1);
        cr_(16'h5f30, S_BYTES, 1'b1);
        cr_(16'h6f01, S_LINEAR, 1'b1);
        cr_(16'h6f02, S_CYCLIC, 1'b1);
        cr_(16'h6f03, S_KEYED, 1'b1);
        cr_(16'h5f31, S_BYTES, 1'b0);
        $display("test create done");
        sel_(16'h6f01, 1'b1);
        sel_(16'h6f01, 1'b1);
        sel_(16'h5f30, 1'b1);
        sel_(16'h6f01, 1'b0);
        sel_(16'h7f10, 1'b1);
        sel_(16'h7f20, 1'b1);
        sel_(16'h2f05, 1'b0);
        sel_(ROOT_FID, 1'b1);
        sel_(16'h2f05, 1'b1);
        sel_(16'h5f30, 1'b0);
        sel_(16'h7f10, 1'b1);
        sel_(16'h7f10, 1'b1);
        $display("test select done");
        sel_(16'h6f01, 1'b1);
        rec_(M_NEXT, 8'h00, 1'b0, 8'h00);
        rec_(M_LAST, 8'h00, 1'b1, 8'h03);
        rec_(M_NEXT, 8'h00, 1'b0, 8'h00);
        rec_(M_PREV, 8'h00, 1'b1, 8'h02);
        op_(OP_ABORT, M_ABS, 1'b0, 16'h0000, 8'h00, 1'b1, 2'd0, 16'h0000);
        rec_(M_CUR, 8'h00, 1'b1, 8'h03);
        // first/last are offered only while no pointer is set
        rec_(M_FIRST, 8'h00, 1'b0, 8'h00);
        rec_(M_ABS, 8'h01, 1'b1, 8'h01);
        rec_(M_PREV, 8'h00, 1'b0, 8'h00);
        rec_(M_SK_BEFORE, 8'h00, 1'b0, 8'h00);
        rec_(M_SK_START, 8'h00, 1'b1, 8'h01);
        rec_(M_ABS, 8'h03, 1'b1, 8'h03);
        rec_(M_SK_AFTER, 8'h00, 1'b0, 8'h00);
        rec_(M_SK_END, 8'h00, 1'b1, 8'h03);
        rec_(M_SK_BEFORE, 8'h00, 1'b1, 8'h02);
        rec_(M_ABS, 8'h04, 1'b0, 8'h00);
        rec_(M_ABS, 8'h00, 1'b0, 8'h00);
        op_(OP_STATUS, M_ABS, 1'b0, 16'h0000, 8'h00, 1'b1, 2'd2, 16'h000c);
        op_(OP_APP_CHECK, M_ABS, 1'b0, 16'h7f10, 8'h00, 1'b1, 2'd0, 16'h0000);
        op_(OP_APP_CHECK, M_ABS, 1'b0, 16'h7f20, 8'h00, 1'b0, 2'd0, 16'h0000);
        sel_(16'h6f01, 1'b1);
        rec_(M_FIRST, 8'h00, 1'b1, 8'h01);
        $display("test linear done");
        sel_(16'h6f02, 1'b1);
        rec_(M_CUR, 8'h00, 1'b1, 8'h01);
        rec_(M_PREV, 8'h00, 1'b1, 8'h03);
        rec_(M_NEXT, 8'h00, 1'b1, 8'h01);
        op_(OP_RECORD, M_NEXT, 1'b1, 16'h0000, 8'h00, 1'b0, 2'd0, 16'h0000);
        op_(OP_RECORD, M_PREV, 1'b1, 16'h0000, 8'h00, 1'b1, 2'd3, 16'h0003);
        op_(OP_COMMIT, M_ABS, 1'b0, 16'h0000, 8'h00, 1'b1, 2'd0, 16'h0000);
        rec_(M_CUR, 8'h00, 1'b1, 8'h01);
        op_(OP_RECORD, M_CUR, 1'b0, 16'h0000, 8'h00, 1'b1, 2'd3, 16'h0003);
        sel_(16'h6f03, 1'b1);
        rec_(M_ABS, 8'h02, 1'b1, 8'h02);
        rec_(M_NEXT, 8'h00, 1'b0, 8'h00);
        rec_(M_FIRST, 8'h00, 1'b0, 8'h00);
        $display("test cyclic and key done");
        sel_(ROOT_FID, 1'b1);
        sel_(16'h2f05, 1'b1);
        op_(OP_BYTES, M_ABS, 1'b0, FIRST_OFFSET, 8'h10, 1'b1, 2'd0, 16'h0000);
        op_(OP_BYTES, M_ABS, 1'b0, 16'h0001, 8'h10, 1'b0, 2'd0, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            o = $urandom % 17;
            c = $urandom % 17;
            op_(OP_BYTES, M_ABS, 1'b0, 16'(o), 8'(c), (o + c) <= 16, 2'd2, (o + c) <= 16 ? 16'(o) : 16'h0000);
        end
        cfs_host_model_inst.idle();
        $display("test bytes done");
        repeat (3) @(negedge clk);
        srst = 1'b1;
        @(negedge clk);
        srst = 1'b0;
        chk(cur_dir_fid, ROOT_FID);
        chk(16'(ef_selected), 16'h0000);
        chk(cur_ef_fid, 16'h0000);
        ed = ROOT_FID;
        ee = 1'b0;
        ei = 16'h0000;
        repeat (2) @(negedge clk);
        sel_(16'h6f01, 1'b0);
        cfs_host_model_inst.idle();
        repeat (3) @(negedge clk);
        chk(16'(q.size()), 16'h0000);
        $display("test reset done");
        test_done();
    end
endmodule : cfs_card_file_selector_tb_top
